// file: gdsr_top.v
/*
 Gate delay status register bank: four read-only effective delay words,
 read over the serial register port, and per-bridge regulation flags on regulating_o.
 Assumes the gate control delivers measurements and regulation levels on
 clk_sys_i, and the serial front end gives a synchronous read strobe.
 Host writes to these addresses are accepted on the port and dropped.
 Restart only clears the read path; the stored codes ride through it.
 Soft reset and power-on reset clear codes, flags and read data alike.
*/
// What this block does
// - Bits 15:14 and 7:6 of every delay status word always read zero.
// - Bits 13:8 hold the six-bit turn-off delay code in 53.3 ns steps.
// - Bits 5:0 hold the six-bit turn-on delay code in 53.3 ns steps.
// - Four read-only words for bridges 1 to 4 sit at addresses 0x53 to 0x56.
// - Power-on and soft reset clear all bits of all four words.
// - Restart clears the registered read data and read hit and leaves the codes as they were.
// - Codes show the delays applied by gate control and host writes never change them.
// - Each bridge has a flag that is 1 while either of its delays is in regulation.
`timescale 1ns/10ps
`include "gdsr_defines.vh"

module gdsr_top (
    // Clock and resets
    input wire clk_sys_i,
    input wire rst_i,
    input wire soft_rst_i,
    input wire restart_i,
    // Gate control measurements, one lane per bridge
    input wire [3:0] meas_valid_i,
    input wire [4*`GDSR_MEAS_W-1:0] meas_on_i,
    input wire [4*`GDSR_MEAS_W-1:0] meas_off_i,
    input wire [3:0] regulating_i,
    // Register port
    input wire rd_en_i,
    input wire wr_en_i,
    input wire [`GDSR_ADDR_W-1:0] addr_i,
    input wire [`GDSR_WORD_W-1:0] wdata_i,
    output reg [`GDSR_WORD_W-1:0] rdata_o,
    output reg rd_hit_o,
    // Status
    output reg [3:0] regulating_o
);

    // ==========================================================
    // Decoder lane codes
    localparam [2:0] LANE_NONE = 3'h0;
    localparam [2:0] LANE_HB1 = 3'h4;
    localparam [2:0] LANE_HB2 = 3'h5;
    localparam [2:0] LANE_HB3 = 3'h6;
    localparam [2:0] LANE_HB4 = 3'h7;

    // ==========================================================
    // Internal nets
    wire [4*`GDSR_CODE_W-1:0] on_codes;
    wire [4*`GDSR_CODE_W-1:0] off_codes;
    wire [3:0] reg_flags;
    wire [`GDSR_CODE_W-1:0] bridge1_on_delay_code;
    wire [`GDSR_CODE_W-1:0] bridge2_on_delay_code;
    wire [`GDSR_CODE_W-1:0] bridge3_on_delay_code;
    wire [`GDSR_CODE_W-1:0] bridge4_on_delay_code;
    wire [`GDSR_CODE_W-1:0] bridge1_off_delay_code;
    wire [`GDSR_CODE_W-1:0] bridge2_off_delay_code;
    wire [`GDSR_CODE_W-1:0] bridge3_off_delay_code;
    wire [`GDSR_CODE_W-1:0] bridge4_off_delay_code;
    wire bridge1_delay_regulating_flag;
    wire bridge2_delay_regulating_flag;
    wire bridge3_delay_regulating_flag;
    wire bridge4_delay_regulating_flag;
    wire [`GDSR_WORD_W-1:0] hb1_effective_delay_status;
    wire [`GDSR_WORD_W-1:0] hb2_effective_delay_status;
    wire [`GDSR_WORD_W-1:0] hb3_effective_delay_status;
    wire [`GDSR_WORD_W-1:0] hb4_effective_delay_status;
    reg [`GDSR_WORD_W-1:0] rdata_next;
    reg hit_next;

    // ==========================================================
    // Address decode
    function [2:0] decode_addr;
        input [`GDSR_ADDR_W-1:0] a;
        begin
            if (a == `GDSR_ADDR_HB1) begin
                decode_addr = 3'h4;
            end else if (a == `GDSR_ADDR_HB2) begin
                decode_addr = 3'h5;
            end else if (a == `GDSR_ADDR_HB3) begin
                decode_addr = 3'h6;
            end else if (a == `GDSR_ADDR_HB4) begin
                decode_addr = 3'h7;
            end else begin
                decode_addr = 3'h0;
            end
        end
    endfunction

    // ==========================================================
    // Per-bridge slots
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : slot
            gdsr_bridge_slot u_slot (
                .clk_sys_i(clk_sys_i),
                .rst_i(rst_i),
                .soft_rst_i(soft_rst_i),
                .meas_valid_i(meas_valid_i[g]),
                .meas_on_i(meas_on_i[g*`GDSR_MEAS_W +: `GDSR_MEAS_W]),
                .meas_off_i(meas_off_i[g*`GDSR_MEAS_W +: `GDSR_MEAS_W]),
                .regulating_i(regulating_i[g]),
                .on_code_o(on_codes[g*`GDSR_CODE_W +: `GDSR_CODE_W]),
                .off_code_o(off_codes[g*`GDSR_CODE_W +: `GDSR_CODE_W]),
                .regulating_o(reg_flags[g])
            );
        end
    endgenerate

    // ==========================================================
    // Named per-bridge views
    assign bridge1_on_delay_code = on_codes[0 +: `GDSR_CODE_W];
    assign bridge2_on_delay_code = on_codes[`GDSR_CODE_W +: `GDSR_CODE_W];
    assign bridge3_on_delay_code = on_codes[2*`GDSR_CODE_W +: `GDSR_CODE_W];
    assign bridge4_on_delay_code = on_codes[3*`GDSR_CODE_W +: `GDSR_CODE_W];
    assign bridge1_off_delay_code = off_codes[0 +: `GDSR_CODE_W];
    assign bridge2_off_delay_code = off_codes[`GDSR_CODE_W +: `GDSR_CODE_W];
    assign bridge3_off_delay_code = off_codes[2*`GDSR_CODE_W +: `GDSR_CODE_W];
    assign bridge4_off_delay_code = off_codes[3*`GDSR_CODE_W +: `GDSR_CODE_W];
    assign bridge1_delay_regulating_flag = reg_flags[0];
    assign bridge2_delay_regulating_flag = reg_flags[1];
    assign bridge3_delay_regulating_flag = reg_flags[2];
    assign bridge4_delay_regulating_flag = reg_flags[3];

    // ==========================================================
    // Word assembly
    // Reserved bits are constant zero, so no reset kind can expose junk there
    function [`GDSR_WORD_W-1:0] assemble_word;
        input [`GDSR_CODE_W-1:0] off_code;
        input [`GDSR_CODE_W-1:0] on_code;
        begin
            assemble_word = `GDSR_RESET_WORD;
            assemble_word[`GDSR_OFF_MSB:`GDSR_OFF_LSB] = off_code;
            assemble_word[`GDSR_ON_MSB:`GDSR_ON_LSB] = on_code;
        end
    endfunction

    assign hb1_effective_delay_status =
        assemble_word(bridge1_off_delay_code, bridge1_on_delay_code);
    assign hb2_effective_delay_status =
        assemble_word(bridge2_off_delay_code, bridge2_on_delay_code);
    assign hb3_effective_delay_status =
        assemble_word(bridge3_off_delay_code, bridge3_on_delay_code);
    assign hb4_effective_delay_status =
        assemble_word(bridge4_off_delay_code, bridge4_on_delay_code);

    // ==========================================================
    // Read mux; writes are deliberately ignored, words are read-only
    always @* begin
        rdata_next = `GDSR_RESET_WORD;
        hit_next = 1'b0;
        if (rd_en_i) begin
            if (decode_addr(addr_i) == LANE_HB1) begin
                hit_next = 1'b1;
                rdata_next = hb1_effective_delay_status;
            end else if (decode_addr(addr_i) == LANE_HB2) begin
                hit_next = 1'b1;
                rdata_next = hb2_effective_delay_status;
            end else if (decode_addr(addr_i) == LANE_HB3) begin
                hit_next = 1'b1;
                rdata_next = hb3_effective_delay_status;
            end else if (decode_addr(addr_i) == LANE_HB4) begin
                hit_next = 1'b1;
                rdata_next = hb4_effective_delay_status;
            end else begin
                hit_next = 1'b0;
                rdata_next = `GDSR_RESET_WORD;
            end
        end
    end

    // ==========================================================
    // Registered read data
    // Restart clears only the read path; stored codes survive it
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= `GDSR_RESET_WORD;
        end else if (soft_rst_i) begin
            rdata_o <= `GDSR_RESET_WORD;
        end else if (restart_i) begin
            rdata_o <= `GDSR_RESET_WORD;
        end else begin
            rdata_o <= rdata_next;
        end
    end

    // ==========================================================
    // Registered read acknowledge
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rd_hit_o <= 1'b0;
        end else if (soft_rst_i || restart_i) begin
            rd_hit_o <= 1'b0;
        end else begin
            rd_hit_o <= hit_next;
        end
    end

    // ==========================================================
    // Registered regulation flags
    // Soft reset clears flags together with the codes
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            regulating_o <= 4'h0;
        end else if (soft_rst_i) begin
            regulating_o <= 4'h0;
        end else begin
            regulating_o <= {bridge4_delay_regulating_flag,
                             bridge3_delay_regulating_flag,
                             bridge2_delay_regulating_flag,
                             bridge1_delay_regulating_flag};
        end
    end

endmodule

// file: gdsr_defines.vh
/*
 Constants for the gate delay status register bank: register addresses,
 field positions, reset values. Assumes inclusion by bare name.
*/
`ifndef GDSR_DEFINES_VH
`define GDSR_DEFINES_VH

// ==========================================================
// Register addresses (7-bit)
`define GDSR_ADDR_HB1 7'h53
`define GDSR_ADDR_HB2 7'h54
`define GDSR_ADDR_HB3 7'h55
`define GDSR_ADDR_HB4 7'h56
`define GDSR_ADDR_W 7

// ==========================================================
// Field layout
`define GDSR_OFF_MSB 13
`define GDSR_OFF_LSB 8
`define GDSR_ON_MSB 5
`define GDSR_ON_LSB 0
`define GDSR_CODE_W 6
`define GDSR_CODE_MAX 6'h3F
`define GDSR_MEAS_W 8
`define GDSR_WORD_W 16

// ==========================================================
// Reset values and step
`define GDSR_RESET_WORD 16'h0000
`define GDSR_RESET_CODE 6'h00
`define GDSR_STEP_PS 53300

`endif

// file: gdsr_bridge_slot.v
/*
 One half-bridge delay status slot: holds the on and off delay codes and
 the regulation flag. Assumes measurement strobes are on clk_sys_i.
*/
`timescale 1ns/10ps
`include "gdsr_defines.vh"

module gdsr_bridge_slot (
    // Clock and resets
    input wire clk_sys_i,
    input wire rst_i,
    input wire soft_rst_i,
    // Measurement
    input wire meas_valid_i,
    input wire [`GDSR_MEAS_W-1:0] meas_on_i,
    input wire [`GDSR_MEAS_W-1:0] meas_off_i,
    input wire regulating_i,
    // Status
    output reg [`GDSR_CODE_W-1:0] on_code_o,
    output reg [`GDSR_CODE_W-1:0] off_code_o,
    output reg regulating_o
);

    // ==========================================================
    // Saturation
    function [`GDSR_CODE_W-1:0] sat6;
        input [`GDSR_MEAS_W-1:0] v;
        begin
            if (v > {2'h0, `GDSR_CODE_MAX}) begin
                sat6 = `GDSR_CODE_MAX;
            end else begin
                sat6 = v[`GDSR_CODE_W-1:0];
            end
        end
    endfunction

    // ==========================================================
    // Code storage; restart does not touch these
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            on_code_o <= `GDSR_RESET_CODE;
            off_code_o <= `GDSR_RESET_CODE;
            regulating_o <= 1'b0;
        end else if (soft_rst_i) begin
            on_code_o <= `GDSR_RESET_CODE;
            off_code_o <= `GDSR_RESET_CODE;
            regulating_o <= 1'b0;
        end else begin
            regulating_o <= regulating_i;
            if (meas_valid_i) begin
                on_code_o <= sat6(meas_on_i);
                off_code_o <= sat6(meas_off_i);
            end
        end
    end

endmodule

// file: gdsr_asserts.sv
/* Port checker for gdsr_top. Assumes a single clock domain; bound below. */
`timescale 1ns/10ps
module gdsr_asserts (
    // Clock and resets
    input wire clk_sys_i,
    input wire rst_i,
    input wire soft_rst_i,
    input wire restart_i,
    // Inputs
    input wire [3:0] meas_valid_i,
    input wire [31:0] meas_on_i,
    input wire [3:0] regulating_i,
    input wire rd_en_i,
    input wire [6:0] addr_i,
    // Outputs
    input wire [15:0] rdata_o,
    input wire rd_hit_o,
    input wire [3:0] regulating_o
);
// ====
// Checks
default clocking @(posedge clk_sys_i); endclocking
default disable iff (rst_i);
wire quiet = !soft_rst_i && !restart_i;
wire hit = rd_en_i && addr_i >= 7'h53 && addr_i <= 7'h56;
sequence s_read1; hit && quiet && meas_valid_i == 4'h0; endsequence
sequence s_sat; meas_valid_i[0] && meas_on_i[7:0] > 8'h3F && quiet; endsequence
sequence s_read_hb1; hit && quiet && addr_i == 7'h53 && !meas_valid_i[0]; endsequence
a_reserved_zero: assert property (rdata_o[15:14] == 2'h0 && rdata_o[7:6] == 2'h0)
    else $error("reserved bits set");
a_hit_answer: assert property (hit && quiet |=> rd_hit_o)
    else $error("mapped read gave no hit");
a_miss_quiet: assert property (!hit |=> !rd_hit_o && rdata_o == 16'h0000)
    else $error("output without mapped read");
a_soft_clear: assert property (soft_rst_i |=> rdata_o == 16'h0000 && regulating_o == 4'h0)
    else $error("soft reset left state");
a_restart_clear: assert property (restart_i |=> rdata_o == 16'h0000)
    else $error("restart left read data");
a_flag_on: assert property ((regulating_i == 4'hF && quiet)[*3] |-> regulating_o == 4'hF)
    else $error("flags not set");
a_word_stable: assert property (s_read1 ##1 hit && quiet && $stable(addr_i) |=> $stable(rdata_o))
    else $error("word changed without measurement");
a_code_sat: assert property (s_sat ##1 s_read_hb1 |=> rdata_o[5:0] == 6'h3F)
    else $error("code not saturated");
endmodule
bind gdsr_top gdsr_asserts u_gdsr_asserts (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .soft_rst_i(soft_rst_i), .restart_i(restart_i), .meas_valid_i(meas_valid_i),
    .meas_on_i(meas_on_i), .regulating_i(regulating_i), .rd_en_i(rd_en_i), .addr_i(addr_i),
    .rdata_o(rdata_o), .rd_hit_o(rd_hit_o), .regulating_o(regulating_o));

// file: gdsr_top_tb.sv
/* Random and corner test of gdsr_top. Assumes the checker is bound. */
`timescale 1ns/10ps
module gdsr_top_tb;
reg clk_sys_i = 0, rst_i = 1, soft_rst_i = 0, restart_i = 0, rd_en_i = 0, wr_en_i = 0;
reg [3:0] meas_valid_i = 0, regulating_i = 0;
reg [31:0] meas_on_i = 0, meas_off_i = 0;
reg [6:0] addr_i = 0;
reg [15:0] wdata_i = 0;
wire [15:0] rdata_o;
wire rd_hit_o;
wire [3:0] regulating_o;
integer fails = 0, checked = 0, seed = 32'h04EA2963, i, g;
reg [15:0] ew [0:3];
always #10 clk_sys_i = ~clk_sys_i;
gdsr_top u_gdsr_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i),
    .restart_i(restart_i), .meas_valid_i(meas_valid_i), .meas_on_i(meas_on_i),
    .meas_off_i(meas_off_i), .regulating_i(regulating_i), .rd_en_i(rd_en_i),
    .wr_en_i(wr_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .rd_hit_o(rd_hit_o), .regulating_o(regulating_o));
// ====
// Helpers
function [15:0] word(input [7:0] on, input [7:0] off);
    word = {2'h0, (off > 8'h3F) ? 6'h3F : off[5:0], 2'h0, (on > 8'h3F) ? 6'h3F : on[5:0]};
endfunction
task chk(input [63:0] nm, input [16:0] seen, input [16:0] exp);
    begin
        checked = checked + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("CHECK FAILED %0s expected %h seen %h", nm, exp, seen);
        end
    end
endtask
task rd(input [6:0] a, input [16:0] exp);
    begin
        rd_en_i = 1;
        addr_i = a;
        @(negedge clk_sys_i) rd_en_i = 0;
        chk("read", {rd_hit_o, rdata_o}, exp);
        @(negedge clk_sys_i);
    end
endtask
task rd_all;
    for (g = 0; g < 4; g = g + 1) rd(7'h53 + g[6:0], {1'b1, ew[g]});
endtask
task final_report;
    begin
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    end
endtask
initial begin
    #200000;
    fails = fails + 1;
    final_report;
end
// ====
// Main sequence
initial begin
    for (g = 0; g < 4; g = g + 1) ew[g] = 16'h0000;
    repeat (3) @(negedge clk_sys_i);
    rst_i = 0;
    rd_all;
    rd(7'h52, 17'h0);
    rd(7'h57, 17'h0);
    for (i = 0; i < 40; i = i + 1) begin
        g = i % 4;
        meas_on_i = $random(seed);
        meas_off_i = $random(seed);
        regulating_i = $random(seed);
        if (i == 0) meas_on_i[7:0] = 8'h40;
        if (i == 0) meas_off_i[7:0] = 8'h3F;
        meas_valid_i = 4'h1 << g;
        wr_en_i = 1;
        wdata_i = $random(seed);
        addr_i = 7'h53 + g[6:0];
        ew[g] = word(meas_on_i[8*g +: 8], meas_off_i[8*g +: 8]);
        @(negedge clk_sys_i);
        meas_valid_i = 0;
        wr_en_i = 0;
        rd(7'h53 + g[6:0], {1'b1, ew[g]});
    end
    rd_en_i = 1;
    addr_i = 7'h54;
    repeat (2) @(negedge clk_sys_i);
    rd_en_i = 0;
    chk("b2b", {rd_hit_o, rdata_o}, {1'b1, ew[1]});
    regulating_i = 4'hF;
    repeat (3) @(negedge clk_sys_i);
    chk("flags", {13'h0, regulating_o}, 17'h0F);
    regulating_i = 4'h0;
    restart_i = 1;
    @(negedge clk_sys_i) restart_i = 0;
    rd_all;
    soft_rst_i = 1;
    @(negedge clk_sys_i) soft_rst_i = 0;
    for (g = 0; g < 4; g = g + 1) ew[g] = 16'h0000;
    rd_all;
    chk("flags0", {13'h0, regulating_o}, 17'h0);
    final_report;
end
endmodule
